// file: rtl/rivm_pkg.sv
package rivm_pkg;

  // Program-memory word address width.
  localparam int ADDR_W = 13;

  // Number of table entries, reset included.
  localparam int NUM_VECTORS = 26;
  localparam int SRC_W       = 5;

  // Fuse encoding: one means unprogrammed, zero means programmed.
  localparam logic FUSE_UNPROGRAMMED = 1'h1;
  localparam logic FUSE_PROGRAMMED   = 1'h0;

  // Default reset vector.
  localparam logic [ADDR_W-1:0] RESET_VEC_ADDR = 13'h0000;

  // Table spacing for each variant.
  localparam logic [ADDR_W-1:0] SPACING_WIDE   = 13'h0002;
  localparam logic [ADDR_W-1:0] SPACING_NARROW = 13'h0001;

  // Boot section start for the wide variant with a 2K-byte boot section.
  localparam logic [ADDR_W-1:0] BOOT_START_WIDE   = 13'h1C00;
  // Boot section start for the narrow variant with a 2K-byte boot section.
  localparam logic [ADDR_W-1:0] BOOT_START_NARROW = 13'h0C00;

  // Source indices in table order; index zero is reset.
  localparam logic [SRC_W-1:0] SRC_RESET        = 5'h00;
  localparam logic [SRC_W-1:0] SRC_EXT0         = 5'h01;
  localparam logic [SRC_W-1:0] SRC_EXT1         = 5'h02;
  localparam logic [SRC_W-1:0] SRC_PCHG_A       = 5'h03;
  localparam logic [SRC_W-1:0] SRC_PCHG_B       = 5'h04;
  localparam logic [SRC_W-1:0] SRC_PCHG_C       = 5'h05;
  localparam logic [SRC_W-1:0] SRC_WATCHDOG     = 5'h06;
  localparam logic [SRC_W-1:0] SRC_CNT2_CMPA    = 5'h07;
  localparam logic [SRC_W-1:0] SRC_CNT2_CMPB    = 5'h08;
  localparam logic [SRC_W-1:0] SRC_CNT2_OVF     = 5'h09;
  localparam logic [SRC_W-1:0] SRC_CNT1_CAPT    = 5'h0A;
  localparam logic [SRC_W-1:0] SRC_CNT1_CMPA    = 5'h0B;
  localparam logic [SRC_W-1:0] SRC_CNT1_CMPB    = 5'h0C;
  localparam logic [SRC_W-1:0] SRC_CNT1_OVF     = 5'h0D;
  localparam logic [SRC_W-1:0] SRC_CNT0_CMPA    = 5'h0E;
  localparam logic [SRC_W-1:0] SRC_CNT0_CMPB    = 5'h0F;
  localparam logic [SRC_W-1:0] SRC_CNT0_OVF     = 5'h10;
  localparam logic [SRC_W-1:0] SRC_SPI_DONE     = 5'h11;
  localparam logic [SRC_W-1:0] SRC_UART_RX      = 5'h12;
  localparam logic [SRC_W-1:0] SRC_UART_TXEMPTY = 5'h13;
  localparam logic [SRC_W-1:0] SRC_UART_TX      = 5'h14;
  localparam logic [SRC_W-1:0] SRC_ADC_DONE     = 5'h15;
  localparam logic [SRC_W-1:0] SRC_EEPROM_READY = 5'h16;
  localparam logic [SRC_W-1:0] SRC_COMPARATOR   = 5'h17;
  localparam logic [SRC_W-1:0] SRC_TWO_WIRE     = 5'h18;
  localparam logic [SRC_W-1:0] SRC_PROG_STORE   = 5'h19;
  localparam logic [SRC_W-1:0] SRC_LAST         = 5'h19;

  // Default wide-variant addresses checked by the assertions.
  localparam logic [ADDR_W-1:0] VEC_EXT0_WIDE       = 13'h0002;
  localparam logic [ADDR_W-1:0] VEC_PROG_STORE_WIDE = 13'h0032;

  // Variant selection.
  typedef enum logic {
    RIVM_VAR_NARROW,
    RIVM_VAR_WIDE
  } rivm_variant_t;

endpackage

// file: rtl/rivm_vector_map.sv
`timescale 1ns/1ps

module rivm_vector_map
  import rivm_pkg::*;
#(
  parameter rivm_variant_t VARIANT = RIVM_VAR_WIDE
) (
  input  wire logic              ref_clk,
  input  wire logic              reset,
  input  wire logic              boot_reset_fuse,
  input  wire logic              vector_table_select,
  input  wire logic              vec_req,
  input  wire logic [SRC_W-1:0]  vec_src,
  output logic                   vec_valid,
  output logic                   vec_err,
  output logic [ADDR_W-1:0]      vec_addr,
  output logic [ADDR_W-1:0]      reset_addr
);

  localparam logic [ADDR_W-1:0] SPACING =
    (VARIANT == RIVM_VAR_WIDE) ? SPACING_WIDE : SPACING_NARROW;
  localparam logic [ADDR_W-1:0] BOOT_START =
    (VARIANT == RIVM_VAR_WIDE) ? BOOT_START_WIDE : BOOT_START_NARROW;

  logic              fuse_reg;
  logic              fuse_cap_reg;
  logic              vec_valid_next;
  logic              vec_err_next;
  logic [ADDR_W-1:0] vec_addr_next;

  // Returns the default table address of a source; slots follow table order.
  function automatic logic [ADDR_W-1:0] table_addr(
    input logic [SRC_W-1:0] src
  );
    logic [ADDR_W-1:0] idx;
    idx = {{(ADDR_W-SRC_W){1'b0}}, src};
    table_addr = ADDR_W'(idx * SPACING);
  endfunction

  // Strap capture after reset release, so the async reset takes a constant.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      fuse_cap_reg <= 1'b0;
      fuse_reg     <= FUSE_UNPROGRAMMED;
    end else if (!fuse_cap_reg) begin
      fuse_cap_reg <= 1'b1;
      fuse_reg     <= boot_reset_fuse;
    end
  end

  // fuse redirect: zero means programmed, so reset goes to boot start.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      reset_addr <= RESET_VEC_ADDR;
    end else if (!fuse_cap_reg) begin
      reset_addr <= (boot_reset_fuse == FUSE_PROGRAMMED) ? BOOT_START
                                                         : RESET_VEC_ADDR;
    end
  end

  // Vector lookup. The table slot number times the spacing gives the
  // default address, so every entry but reset follows from table order.
  // table order.
  // relocation adds the boot start when vector select is set, except for reset, which takes reset_addr.
  // narrow variant and wide variant come from the spacing and boot start constants.
  always_comb begin
    vec_valid_next = 1'b0;
    vec_err_next   = 1'b0;
    vec_addr_next  = vec_addr;
    if (vec_req) begin
      if (vec_src > SRC_LAST) begin
        vec_err_next = 1'b1;
      end else if (vec_src == SRC_RESET) begin
        vec_valid_next = 1'b1;
        vec_addr_next  = reset_addr;
      end else begin
        vec_valid_next = 1'b1;
        vec_addr_next  = vector_table_select
                       ? ADDR_W'(table_addr(vec_src) + BOOT_START)
                       : table_addr(vec_src);
      end
    end
  end

  // Registered answer one cycle after the request.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      vec_valid <= 1'b0;
      vec_err   <= 1'b0;
      vec_addr  <= RESET_VEC_ADDR;
    end else begin
      vec_valid <= vec_valid_next;
      vec_err   <= vec_err_next;
      vec_addr  <= vec_addr_next;
    end
  end

  // Assertions guarding the map.
  sequence req_s(logic [SRC_W-1:0] s);
    vec_req && vec_src == s && !vector_table_select;
  endsequence

  sequence req_boot_s(logic [SRC_W-1:0] s);
    vec_req && vec_src == s && vector_table_select;
  endsequence

  answer_timing_a: assert property (
    @(posedge ref_clk) disable iff (reset)
    (vec_req && vec_src <= SRC_LAST) |=> vec_valid && !vec_err)
    else $error("vector request not answered next cycle");

  ext0_default_a: assert property (
    @(posedge ref_clk) disable iff (reset)
    req_s(SRC_EXT0) |=> vec_addr == ADDR_W'(SPACING))
    else $error("external request 0 vector wrong");

  pchg_c_a: assert property (
    @(posedge ref_clk) disable iff (reset)
    req_s(SRC_PCHG_C) |=> vec_addr == ADDR_W'(SPACING * SRC_PCHG_C))
    else $error("pin change c vector wrong");

  watchdog_slot_a: assert property (
    @(posedge ref_clk) disable iff (reset)
    req_s(SRC_WATCHDOG) |=> vec_addr == ADDR_W'(SPACING * SRC_WATCHDOG))
    else $error("watchdog vector wrong");

  cnt2_ovf_a: assert property (
    @(posedge ref_clk) disable iff (reset)
    req_s(SRC_CNT2_OVF) |=> vec_addr == ADDR_W'(SPACING * SRC_CNT2_OVF))
    else $error("counter 2 overflow vector wrong");

  cnt1_ovf_a: assert property (
    @(posedge ref_clk) disable iff (reset)
    req_s(SRC_CNT1_OVF) |=> vec_addr == ADDR_W'(SPACING * SRC_CNT1_OVF))
    else $error("counter 1 overflow vector wrong");

  cnt0_ovf_a: assert property (
    @(posedge ref_clk) disable iff (reset)
    req_s(SRC_CNT0_OVF) |=> vec_addr == ADDR_W'(SPACING * SRC_CNT0_OVF))
    else $error("counter 0 overflow vector wrong");

  spi_done_a: assert property (
    @(posedge ref_clk) disable iff (reset)
    req_s(SRC_SPI_DONE) |=> vec_addr == ADDR_W'(SPACING * SRC_SPI_DONE))
    else $error("serial transfer vector wrong");

  uart_tx_a: assert property (
    @(posedge ref_clk) disable iff (reset)
    req_s(SRC_UART_TX) |=> vec_addr == ADDR_W'(SPACING * SRC_UART_TX))
    else $error("uart transmit vector wrong");

  prog_store_a: assert property (
    @(posedge ref_clk) disable iff (reset)
    req_s(SRC_PROG_STORE) |=> vec_addr == ADDR_W'(SPACING * SRC_PROG_STORE))
    else $error("program store vector wrong");

  boot_reloc_a: assert property (
    @(posedge ref_clk) disable iff (reset)
    req_boot_s(SRC_EXT0) |=> vec_addr == ADDR_W'(BOOT_START + SPACING))
    else $error("relocated first vector wrong");

  boot_last_a: assert property (
    @(posedge ref_clk) disable iff (reset)
    req_boot_s(SRC_PROG_STORE)
      |=> vec_addr == ADDR_W'(BOOT_START + SPACING * SRC_PROG_STORE))
    else $error("relocated last vector wrong");

  reset_vec_a: assert property (
    @(posedge ref_clk) disable iff (reset)
    fuse_cap_reg |-> reset_addr ==
      ((fuse_reg == FUSE_PROGRAMMED) ? BOOT_START : RESET_VEC_ADDR))
    else $error("reset address disagrees with fuse");

  reset_default_a: assert property (
    @(posedge ref_clk) disable iff (reset)
    (vec_req && vec_src == SRC_RESET && fuse_reg == FUSE_UNPROGRAMMED
      && fuse_cap_reg) |=> vec_addr == RESET_VEC_ADDR)
    else $error("default reset vector wrong");

  bad_src_a: assert property (
    @(posedge ref_clk) disable iff (reset)
    (vec_req && vec_src > SRC_LAST) |=> vec_err && !vec_valid)
    else $error("out of range source not flagged");

  ext1_default_a: assert property (
    @(posedge ref_clk) disable iff (reset)
    req_s(SRC_EXT1) |=> vec_addr == ADDR_W'(SPACING * SRC_EXT1))
    else $error("external request 1 vector wrong");

  pchg_a_a: assert property (
    @(posedge ref_clk) disable iff (reset)
    req_s(SRC_PCHG_A) |=> vec_addr == ADDR_W'(SPACING * SRC_PCHG_A))
    else $error("pin change a vector wrong");

  cnt2_cmpa_a: assert property (
    @(posedge ref_clk) disable iff (reset)
    req_s(SRC_CNT2_CMPA) |=> vec_addr == ADDR_W'(SPACING * SRC_CNT2_CMPA))
    else $error("counter 2 compare a vector wrong");

  cnt1_capt_a: assert property (
    @(posedge ref_clk) disable iff (reset)
    req_s(SRC_CNT1_CAPT) |=> vec_addr == ADDR_W'(SPACING * SRC_CNT1_CAPT))
    else $error("counter 1 capture vector wrong");

  cnt0_cmpa_a: assert property (
    @(posedge ref_clk) disable iff (reset)
    req_s(SRC_CNT0_CMPA) |=> vec_addr == ADDR_W'(SPACING * SRC_CNT0_CMPA))
    else $error("counter 0 compare a vector wrong");

  uart_rx_a: assert property (
    @(posedge ref_clk) disable iff (reset)
    req_s(SRC_UART_RX) |=> vec_addr == ADDR_W'(SPACING * SRC_UART_RX))
    else $error("uart receive vector wrong");

  // The wide table is also held against its fixed first and last entries,
  // so a wrong spacing constant cannot hide behind the slot arithmetic.
  wide_first_a: assert property (
    @(posedge ref_clk) disable iff (reset)
    req_s(SRC_EXT0)
      |=> (VARIANT != RIVM_VAR_WIDE) || vec_addr == VEC_EXT0_WIDE)
    else $error("wide first vector wrong");

  wide_last_a: assert property (
    @(posedge ref_clk) disable iff (reset)
    req_s(SRC_PROG_STORE)
      |=> (VARIANT != RIVM_VAR_WIDE) || vec_addr == VEC_PROG_STORE_WIDE)
    else $error("wide last vector wrong");

  err_addr_hold_a: assert property (
    @(posedge ref_clk) disable iff (reset)
    (vec_req && vec_src > SRC_LAST) |=> $stable(vec_addr))
    else $error("refused source moved the vector address");

  reset_unmoved_a: assert property (
    @(posedge ref_clk) disable iff (reset)
    (vec_req && vec_src == SRC_RESET && fuse_cap_reg)
      |=> vec_addr == $past(reset_addr))
    else $error("reset vector moved by table select");

  idle_quiet_a: assert property (
    @(posedge ref_clk) disable iff (reset)
    !vec_req |=> !vec_valid && !vec_err)
    else $error("answer without a request");

endmodule

// file: verification/rivm_core_model.sv
`timescale 1ns/1ps

module rivm_core_model
  import rivm_pkg::*;
(
  input  wire logic             ref_clk,
  input  wire logic             reset,
  input  wire logic             want_req,
  input  wire logic [SRC_W-1:0] want_src,
  input  wire logic             want_sel,
  output logic                  vec_req,
  output logic [SRC_W-1:0]      vec_src,
  output logic                  vector_table_select
);

  // The core asks for a vector only when the bench wants one.
  // A change of table placement takes a quiet cycle first.
  // select before requests.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      vec_req             <= 1'h0;
      vec_src             <= 5'h00;
      vector_table_select <= 1'h0;
    end else if (want_sel != vector_table_select) begin
      vec_req             <= 1'h0; // No fetch while moving the table.
      vector_table_select <= want_sel;
    end else begin
      vec_req <= want_req;
      vec_src <= want_src;
    end
  end

endmodule

// file: verification/test_reset_irq_vector_map.sv
`timescale 1ns/1ps

module test_reset_irq_vector_map;
  import rivm_pkg::*;

  logic              ref_clk, reset, boot_reset_fuse, chk;
  logic              want_req, want_sel, vec_req, vts, p_req, p_sel;
  logic [SRC_W-1:0]  want_src, vec_src, p_src;
  logic              w_valid, w_err, n_valid, n_err;
  logic [ADDR_W-1:0] w_addr, w_rst, n_addr, n_rst;
  int                fails, n_tests, seed;

  rivm_core_model core (.ref_clk(ref_clk), .reset(reset),
    .want_req(want_req), .want_src(want_src), .want_sel(want_sel),
    .vec_req(vec_req), .vec_src(vec_src), .vector_table_select(vts));
  rivm_vector_map #(.VARIANT(RIVM_VAR_WIDE)) dut (.ref_clk(ref_clk),
    .reset(reset), .boot_reset_fuse(boot_reset_fuse),
    .vector_table_select(vts), .vec_req(vec_req), .vec_src(vec_src),
    .vec_valid(w_valid), .vec_err(w_err), .vec_addr(w_addr),
    .reset_addr(w_rst));
  rivm_vector_map #(.VARIANT(RIVM_VAR_NARROW)) dut_narrow (.ref_clk(ref_clk),
    .reset(reset), .boot_reset_fuse(boot_reset_fuse),
    .vector_table_select(vts), .vec_req(vec_req), .vec_src(vec_src),
    .vec_valid(n_valid), .vec_err(n_err), .vec_addr(n_addr),
    .reset_addr(n_rst));

  // Free-running 50 MHz clock.
  initial begin
    ref_clk = 1'h0;
    forever #10 ref_clk = ~ref_clk;
  end

  // Reference table: reset moves with the fuse, the rest with select.
  function automatic logic [ADDR_W-1:0] exp_vec(input int s, input logic sel,
      input int sp, input logic [ADDR_W-1:0] boot);
    if (s == 0)
      return (boot_reset_fuse === FUSE_UNPROGRAMMED) ? RESET_VEC_ADDR : boot;
    return ADDR_W'(s * sp) + (sel ? boot : 13'h0000);
  endfunction

  task automatic cmp(input logic [ADDR_W-1:0] got, input logic [ADDR_W-1:0] e);
    n_tests++;
    if (got !== e) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, e);
    end
  endtask

  task automatic report_and_stop;
    if (fails == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Remember what the maps saw at each edge.
  always @(posedge ref_clk) begin
    p_req <= vec_req;
    p_src <= vec_src;
    p_sel <= vts;
  end

  // Compare both maps with the reference in mid-cycle.
  always @(negedge ref_clk) begin
    if (chk) begin
      cmp(w_rst, exp_vec(0, 1'h0, 2, BOOT_START_WIDE));
      cmp(n_rst, exp_vec(0, 1'h0, 1, BOOT_START_NARROW));
      cmp(ADDR_W'(w_err), ADDR_W'(p_req && p_src > SRC_LAST));
      cmp(ADDR_W'(w_valid), ADDR_W'(p_req && p_src <= SRC_LAST));
      cmp(ADDR_W'(n_err), ADDR_W'(p_req && p_src > SRC_LAST));
      cmp(ADDR_W'(n_valid), ADDR_W'(p_req && p_src <= SRC_LAST));
      if (p_req && p_src <= SRC_LAST) begin
        cmp(w_addr, exp_vec(p_src, p_sel, 2, BOOT_START_WIDE));
        cmp(n_addr, exp_vec(p_src, p_sel, 1, BOOT_START_NARROW));
      end
    end
  end

  task automatic req(input int s, input logic sel);
    @(posedge ref_clk);
    want_req <= 1'h1;
    want_src <= s[SRC_W-1:0];
    want_sel <= sel;
  endtask

  // One reset with a given fuse, then for each table select a full sweep and random traffic.
  task automatic run(input logic f);
    @(posedge ref_clk);
    reset           <= 1'h1;
    boot_reset_fuse <= f;
    chk             <= 1'h0;
    want_req        <= 1'h0;
    repeat (5) @(posedge ref_clk);
    reset <= 1'h0;
    repeat (3) @(posedge ref_clk);
    chk <= 1'h1;
    for (int sel = 0; sel < 2; sel++) begin
      // The core drops the request that moves the table, so lead with one.
      req(0, sel[0]);
      for (int s = 0; s < 32; s++)
        req(s, sel[0]);
      repeat (100) req($random(seed), sel[0]);
    end
    @(posedge ref_clk);
    want_req <= 1'h0;
    repeat (3) @(posedge ref_clk);
  endtask

  // Main sequence: unprogrammed fuse, then programmed after a new reset.
  initial begin
    seed            = 32'h2ff1;
    fails           = 0;
    n_tests         = 0;
    reset           = 1'h1;
    boot_reset_fuse = 1'h1;
    chk             = 1'h0;
    want_req        = 1'h0;
    want_src        = 5'h00;
    want_sel        = 1'h0;
    run(FUSE_UNPROGRAMMED);
    run(FUSE_PROGRAMMED);
    report_and_stop;
  end

  // Watchdog well beyond the roughly 560 cycles the tests need.
  initial begin
    #100000;
    fails++;
    report_and_stop;
  end

endmodule
